// File: core/fmcfg_top.sv
// Second configuration register with serial bus slave, alert, speed input and PWM gating.
`timescale 1ns/100ps
module fmcfg_top
    import fmcfg_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         sclIn,
    input  wire logic         sdaIn,
    output logic              sdaOut,
    output logic              sdaOe,
    output logic              alertPinOut,
    output logic              alertPinOe,
    input  wire fmcfg_flags_s flags,
    input  wire logic         powerOnSensorFail,
    input  wire logic         speedIn,
    output logic              speedEdge,
    output logic              speedCounterHold,
    input  wire logic         speedRegMode,
    input  wire logic         measureActive,
    input  wire logic         measureDone,
    input  wire logic [15:0]  measuredPeriod,
    input  wire logic [15:0]  targetPeriod,
    input  wire logic [7:0]   dutySetting,
    input  wire logic         pwmWave,
    output logic [7:0]        pwmDuty,
    output logic              pwmPinOut,
    output logic              pwmPinOe,
    output logic              correctionEnable,
    output fmcfg_cfg_s        cfg,
    output logic              deviceReset
);

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]   sclSync;
    logic [1:0]   sdaSync;
    logic [1:0]   speedSync;
    logic         sclDly;
    logic         sdaDly;
    logic         speedDly;
    logic         sclRise;
    logic         sclFall;
    logic         startCond;
    logic         stopCond;
    fmcfg_bus_e   busState;
    fmcfg_phase_e phase;
    logic [7:0]   rxShift;
    logic [7:0]   txShift;
    logic [7:0]   ptr;
    logic [2:0]   bitCnt;
    logic         readMode;
    logic         ackOn;
    logic [7:0]   next_byte;
    logic [7:0]   rdData;
    logic         cfgWe;
    logic         softHit;
    logic         devRst;
    logic         initPend;
    logic [7:0]   rpmDuty;
    logic [7:0]   calcDuty;

    // True on the last bit of a data byte aimed at the register.
    function automatic logic dataLsbToReg(input fmcfg_bus_e   st,
                                          input fmcfg_phase_e ph,
                                          input logic [2:0]   cnt,
                                          input logic [7:0]   p);
        return st == FMCFG_RX && ph == FMCFG_PH_DATA && cnt == FMCFG_LAST_BIT
               && p == FMCFG_REG_CFG2;
    endfunction

    // Pins from outside the clock domain pass two flip-flops first.
    always_ff @(posedge clk) begin
        sclSync   <= {sclSync[0], sclIn};
        sdaSync   <= {sdaSync[0], sdaIn};
        speedSync <= {speedSync[0], speedIn};
        sclDly    <= sclSync[1];
        sdaDly    <= sdaSync[1];
        speedDly  <= speedSync[1];
    end

    assign sclRise   = sclSync[1] & ~sclDly;
    assign sclFall   = ~sclSync[1] & sclDly;
    assign startCond = sclSync[1] & sclDly & sdaDly & ~sdaSync[1];
    assign stopCond  = sclSync[1] & sclDly & ~sdaDly & sdaSync[1];
    assign next_byte = {rxShift[6:0], sdaSync[1]};
    assign devRst    = ~rst_n | deviceReset;
    assign sdaOut    = 1'b0;

    // Only the register address reads back, and its top bit always reads zero.
    always_comb begin
        if (ptr == FMCFG_REG_CFG2) begin
            rdData = {1'b0, cfg[6:0]};
        end else begin
            rdData = FMCFG_READ_ZERO;
        end
    end

    // A data byte to the register with the top bit set is a soft reset.
    assign softHit = sclRise && dataLsbToReg(busState, phase, bitCnt, ptr)
                     && next_byte[FMCFG_BIT_SOFTRST];
    assign cfgWe   = sclRise && dataLsbToReg(busState, phase, bitCnt, ptr)
                     && !next_byte[FMCFG_BIT_SOFTRST];

    ////////////////////////////////////////////////////////////////////////////
    // Serial bus slave.
    always_ff @(posedge clk) begin
        if (devRst) begin
            busState <= FMCFG_IDLE;
            phase    <= FMCFG_PH_ADDR;
            rxShift  <= FMCFG_READ_ZERO;
            txShift  <= FMCFG_READ_ZERO;
            ptr      <= FMCFG_READ_ZERO;
            bitCnt   <= 3'h0;
            readMode <= 1'b0;
            ackOn    <= 1'b0;
            sdaOe    <= 1'b0;
        end else if (startCond) begin
            busState <= FMCFG_RX;
            phase    <= FMCFG_PH_ADDR;
            bitCnt   <= 3'h0;
            ackOn    <= 1'b0;
            sdaOe    <= 1'b0;
        end else if (stopCond) begin
            busState <= FMCFG_IDLE;
            sdaOe    <= 1'b0;
        end else begin
            case (busState)
                FMCFG_RX: begin
                    if (sclRise) begin
                        rxShift <= next_byte;
                        bitCnt  <= bitCnt + 3'h1;
                        if (bitCnt == FMCFG_LAST_BIT) begin
                            busState <= FMCFG_ACK;
                            ackOn    <= 1'b0;
                            if (phase == FMCFG_PH_ADDR) begin
                                readMode <= next_byte[0];
                                if (next_byte[7:1] != FMCFG_BUS_ADDR) begin
                                    busState <= FMCFG_IDLE;
                                end
                            end else if (phase == FMCFG_PH_CMD) begin
                                ptr <= next_byte;
                            end
                        end
                    end
                end
                FMCFG_ACK: begin
                    if (sclFall && !ackOn) begin
                        ackOn <= 1'b1;
                        sdaOe <= 1'b1;
                    end else if (sclFall) begin
                        ackOn  <= 1'b0;
                        bitCnt <= 3'h0;
                        if (phase == FMCFG_PH_ADDR && readMode) begin
                            busState <= FMCFG_TX;
                            txShift  <= rdData;
                            sdaOe    <= ~rdData[7];
                        end else begin
                            busState <= FMCFG_RX;
                            sdaOe    <= 1'b0;
                            phase    <= (phase == FMCFG_PH_ADDR) ? FMCFG_PH_CMD
                                                                 : FMCFG_PH_DATA;
                        end
                    end
                end
                FMCFG_TX: begin
                    if (sclRise) begin
                        bitCnt <= bitCnt + 3'h1;
                        if (bitCnt == FMCFG_LAST_BIT) begin
                            busState <= FMCFG_RACK;
                        end
                    end else if (sclFall) begin
                        txShift <= {txShift[6:0], 1'b0};
                        sdaOe   <= ~txShift[6];
                    end
                end
                FMCFG_RACK: begin
                    if (sclFall) begin
                        sdaOe <= 1'b0;
                    end else if (sclRise) begin
                        busState <= sdaSync[1] ? FMCFG_IDLE : FMCFG_TXLD;
                    end
                end
                FMCFG_TXLD: begin
                    if (sclFall) begin
                        busState <= FMCFG_TX;
                        bitCnt   <= 3'h0;
                        txShift  <= rdData;
                        sdaOe    <= ~rdData[7];
                    end
                end
                default: begin
                    busState <= FMCFG_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Soft reset pulse; the byte is left without acknowledge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            deviceReset <= 1'b0;
        end else begin
            deviceReset <= softHit;
        end
    end

    // Configuration register and power-on sensor failure capture.
    always_ff @(posedge clk) begin
        if (devRst) begin
            cfg      <= fmcfg_cfg_s'(FMCFG_CFG2_RESET);
            initPend <= 1'b1;
        end else begin
            initPend <= 1'b0;
            if (initPend && powerOnSensorFail) begin
                cfg.remoteOvertempIrqEnable <= 1'b0;
            end else if (cfgWe) begin
                cfg <= fmcfg_cfg_s'({1'b0, next_byte[6:0]});
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alert pin is open drain and pulled low by any enabled flag.
    always_ff @(posedge clk) begin
        if (devRst) begin
            alertPinOe <= 1'b0;
        end else begin
            alertPinOe <= (flags.supplyStatusFlag & cfg.supplyStatusIrqEnable)
                        | (flags.remoteOvertempFlag & cfg.remoteOvertempIrqEnable)
                        | (flags.localOvertempFlag & cfg.localOvertempIrqEnable)
                        | (flags.sensorFailFlag & cfg.sensorFailIrqEnable);
        end
    end
    assign alertPinOut = 1'b0;

    // Speed input gating; the counter holds while the input is off.
    always_ff @(posedge clk) begin
        if (devRst) begin
            speedEdge        <= 1'b0;
            speedCounterHold <= 1'b0;
        end else begin
            speedEdge        <= cfg.speedInputEnable & speedSync[1] & ~speedDly;
            speedCounterHold <= ~cfg.speedInputEnable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Speed regulation steps the duty by one per finished measurement.
    always_ff @(posedge clk) begin
        if (devRst) begin
            rpmDuty <= FMCFG_DUTY_ZERO;
        end else if (speedRegMode && measureDone) begin
            if (measuredPeriod > targetPeriod && rpmDuty != FMCFG_DUTY_MAX) begin
                rpmDuty <= rpmDuty + 8'h01;
            end else if (measuredPeriod < targetPeriod && rpmDuty != FMCFG_DUTY_ZERO) begin
                rpmDuty <= rpmDuty - 8'h01;
            end
        end
    end

    assign calcDuty = speedRegMode ? rpmDuty : dutySetting;

    // Duty floors and output drive.
    always_ff @(posedge clk) begin
        if (devRst) begin
            pwmDuty          <= FMCFG_DUTY_ZERO;
            pwmPinOut        <= 1'b0;
            pwmPinOe         <= 1'b1;
            correctionEnable <= 1'b1;
        end else begin
            if (speedRegMode && !cfg.speedMeasureMode && calcDuty < FMCFG_RPM_FLOOR) begin
                pwmDuty <= FMCFG_RPM_FLOOR;
            end else if (calcDuty < FMCFG_MIN_DUTY) begin
                pwmDuty <= FMCFG_DUTY_ZERO;
            end else begin
                pwmDuty <= calcDuty;
            end
            pwmPinOut        <= pwmWave | (measureActive & ~cfg.speedMeasureMode);
            correctionEnable <= ~cfg.speedMeasureMode;
            pwmPinOe         <= cfg.pwmEnable;
        end
    end

endmodule

// File: core/fmcfg_pkg.sv
// Constants and types for the second configuration register block.
package fmcfg_pkg;

    // Register map and reset value.
    localparam logic [7:0] FMCFG_REG_CFG2   = 8'h01;
    localparam logic [7:0] FMCFG_CFG2_RESET = 8'h3D;
    localparam logic [7:0] FMCFG_READ_ZERO  = 8'h00;

    // Field positions inside the register.
    localparam int FMCFG_BIT_SOFTRST = 7;
    localparam int FMCFG_BIT_SUPPLY  = 6;
    localparam int FMCFG_BIT_REMOTE  = 5;
    localparam int FMCFG_BIT_LOCAL   = 4;
    localparam int FMCFG_BIT_SFAIL   = 3;
    localparam int FMCFG_BIT_SPDEN   = 2;
    localparam int FMCFG_BIT_SPDMODE = 1;
    localparam int FMCFG_BIT_PWMEN   = 0;

    // Default serial bus address of the device.
    localparam logic [6:0] FMCFG_BUS_ADDR = 7'h18;

    // Duty cycle scale and floors, in percent of full scale.
    localparam int         FMCFG_DUTY_FULL    = 255;
    localparam int         FMCFG_RPM_FLOOR_PC = 30;
    localparam int         FMCFG_MIN_DUTY_PC  = 7;
    localparam logic [7:0] FMCFG_RPM_FLOOR    =
        8'(FMCFG_DUTY_FULL * FMCFG_RPM_FLOOR_PC / 100);
    localparam logic [7:0] FMCFG_MIN_DUTY     =
        8'(FMCFG_DUTY_FULL * FMCFG_MIN_DUTY_PC / 100);
    localparam logic [7:0] FMCFG_DUTY_ZERO    = 8'h00;
    localparam logic [7:0] FMCFG_DUTY_MAX     = 8'hFF;
    localparam logic [2:0] FMCFG_LAST_BIT     = 3'h7;

    typedef struct packed {
        logic softReset;
        logic supplyStatusIrqEnable;
        logic remoteOvertempIrqEnable;
        logic localOvertempIrqEnable;
        logic sensorFailIrqEnable;
        logic speedInputEnable;
        logic speedMeasureMode;
        logic pwmEnable;
    } fmcfg_cfg_s;

    typedef struct packed {
        logic supplyStatusFlag;
        logic remoteOvertempFlag;
        logic localOvertempFlag;
        logic sensorFailFlag;
    } fmcfg_flags_s;

    typedef enum logic [5:0] {
        FMCFG_IDLE = 6'h01,
        FMCFG_RX   = 6'h02,
        FMCFG_ACK  = 6'h04,
        FMCFG_TX   = 6'h08,
        FMCFG_RACK = 6'h10,
        FMCFG_TXLD = 6'h20
    } fmcfg_bus_e;

    typedef enum logic [2:0] {
        FMCFG_PH_ADDR = 3'h1,
        FMCFG_PH_CMD  = 3'h2,
        FMCFG_PH_DATA = 3'h4
    } fmcfg_phase_e;

endpackage

// File: tb/fmcfg_props.sv
// Concurrent checks on the ports of the second configuration register block.
`timescale 1ns/100ps
module fmcfg_props
    import fmcfg_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_n,
    input wire fmcfg_flags_s flags,
    input wire fmcfg_cfg_s   cfg,
    input wire logic         alertPinOe,
    input wire logic         pwmPinOe,
    input wire logic         correctionEnable,
    input wire logic         speedCounterHold,
    input wire logic         speedEdge,
    input wire logic         pwmPinOut,
    input wire logic         pwmWave,
    input wire logic         measureActive,
    input wire logic         speedRegMode,
    input wire logic [7:0]   dutySetting,
    input wire logic [7:0]   pwmDuty,
    input wire logic         deviceReset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // High once the previous edge saw neither a hard nor a soft reset.
    logic live;
    always_ff @(posedge clk) begin
        live <= rst_n && !deviceReset;
    end
    AST_SR_READ: assert property (cfg.softReset == 1'b0) else $error("reset bit reads one");
    AST_SR_CFG: assert property (deviceReset |=> (cfg | 8'h20) == FMCFG_CFG2_RESET)
        else $error("soft reset left register wrong");
    AST_ALERT: assert property (live |-> alertPinOe == |($past(flags) & $past(cfg[6:3])))
        else $error("alert pin does not follow flags and enables");
    AST_PWM_OE: assert property (live && $stable(cfg) |-> pwmPinOe == cfg.pwmEnable)
        else $error("pwm pin enable wrong");
    AST_CORR: assert property (live && $stable(cfg) |-> correctionEnable == !cfg.speedMeasureMode)
        else $error("correction enable wrong");
    AST_HOLD: assert property (live && $stable(cfg) |-> speedCounterHold == !cfg.speedInputEnable)
        else $error("speed counter hold wrong");
    AST_NO_EDGE: assert property (live && $stable(cfg) && !cfg.speedInputEnable |-> !speedEdge)
        else $error("speed edge while input disabled");
    AST_FORCE: assert property (live && $stable(cfg) && !cfg.speedMeasureMode && $past(measureActive)
        |-> pwmPinOut) else $error("pwm not forced on during measurement");
    AST_FOLLOW: assert property (live && $stable(cfg) && cfg.speedMeasureMode
        |-> pwmPinOut == $past(pwmWave)) else $error("pwm pin does not follow waveform");
    AST_MIN_DUTY: assert property (live && $stable(cfg) && !speedRegMode && $stable(speedRegMode)
        |-> pwmDuty == ($past(dutySetting) < FMCFG_MIN_DUTY ? FMCFG_DUTY_ZERO : $past(dutySetting)))
        else $error("low duty not forced to zero");
    AST_RPM_FLOOR: assert property (live && $stable(cfg) && !cfg.speedMeasureMode && speedRegMode
        && $stable(speedRegMode) |-> pwmDuty >= FMCFG_RPM_FLOOR) else $error("duty below floor");
endmodule
bind fmcfg_top fmcfg_props i_fmcfg_props (.clk, .rst_n, .flags, .cfg, .alertPinOe, .pwmPinOe,
    .correctionEnable, .speedCounterHold, .speedEdge, .pwmPinOut, .pwmWave, .measureActive,
    .speedRegMode, .dutySetting, .pwmDuty, .deviceReset);

// File: tb/fmcfg_host.sv
// Serial management bus host model driving the bus clock and open-drain data line.
`timescale 1ns/100ps
module fmcfg_host
    import fmcfg_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  sdaOe,
    output logic       scl,
    output logic       sdaLine,
    output logic       rdDone,
    output logic [7:0] rdByte
);
    logic sdaLow = 1'b0;
    initial scl = 1'b1;
    initial rdDone = 1'b0;
    // The data line has a pull-up, so it is high when nobody pulls it low.
    assign sdaLine = !(sdaLow || sdaOe);
    task automatic q();
        repeat (2) @(negedge clk);
    endtask
    task automatic start();
        sdaLow = 1'b0;
        // A slave acknowledge is released a few clocks after the bus clock falls.
        q();
        q();
        scl = 1'b1;
        q();
        sdaLow = 1'b1;
        q();
        scl = 1'b0;
    endtask
    task automatic stop();
        q();
        sdaLow = 1'b1;
        q();
        scl = 1'b1;
        q();
        sdaLow = 1'b0;
        q();
    endtask
    // Eight bits out most significant first, then the ninth bit is released and sampled.
    task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic [8:0] b;
        for (int i = 8; i >= 0; i--) begin
            q();
            sdaLow = (i == 0) ? 1'b0 : !d[i - 1];
            q();
            scl = 1'b1;
            q();
            b[i] = sdaLine;
            q();
            scl = 1'b0;
        end
        r = b[8:1];
        ack = !b[0];
    endtask
    task automatic writeReg(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] dat, output logic ack);
        logic [7:0] r;
        logic       a;
        start();
        xfer({dev, 1'b0}, r, a);
        xfer(ptr, r, a);
        xfer(dat, r, ack);
        stop();
    endtask
    task automatic readReg(input logic [6:0] dev, input logic [7:0] ptr);
        logic [7:0] r;
        logic       a;
        start();
        xfer({dev, 1'b0}, r, a);
        xfer(ptr, r, a);
        start();
        xfer({dev, 1'b1}, r, a);
        xfer(8'hFF, rdByte, a);
        stop();
        rdDone = 1'b1;
        @(negedge clk);
        rdDone = 1'b0;
    endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the second configuration register block.
`timescale 1ns/100ps
module tb
    import fmcfg_pkg::*;
;
    logic         clk = 1'b0, rst_n = 1'b0, powerOnSensorFail = 1'b0, speedIn = 1'b0;
    logic         speedRegMode = 1'b0, measureActive = 1'b0, measureDone = 1'b0, pwmWave = 1'b0;
    logic [7:0]   dutySetting = 8'h00, d, expQ[$];
    fmcfg_flags_s flags = '0;
    fmcfg_cfg_s   cfg;
    logic         scl, sdaLine, rdDone, sdaOut, sdaOe, alertPinOut, alertPinOe, speedEdge;
    logic         speedCounterHold, pwmPinOut, pwmPinOe, correctionEnable, deviceReset, a;
    logic [7:0]   rdByte, pwmDuty;
    int           mismatches = 0, compares = 0, resets = 0, seed = 3, edges = 0, e;
    logic [7:0]   duties[4] = '{8'h00, 8'h10, 8'h11, 8'hC8};
    always #20 clk = !clk;
    always begin
        repeat (8) @(negedge clk);
        speedIn = !speedIn;
    end
    always @(posedge clk) if (deviceReset === 1'b1) resets++;
    always @(posedge clk) if (speedEdge === 1'b1) edges++;
    fmcfg_host i_fmcfg_host (.clk(clk), .sdaOe(sdaOe), .scl(scl), .sdaLine(sdaLine),
        .rdDone(rdDone), .rdByte(rdByte));
    fmcfg_top i_fmcfg_top (.clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .alertPinOut(alertPinOut), .alertPinOe(alertPinOe),
        .flags(flags), .powerOnSensorFail(powerOnSensorFail), .speedIn(speedIn),
        .speedEdge(speedEdge), .speedCounterHold(speedCounterHold), .speedRegMode(speedRegMode),
        .measureActive(measureActive), .measureDone(measureDone), .measuredPeriod(16'h0100),
        .targetPeriod(16'h0080), .dutySetting(dutySetting), .pwmWave(pwmWave),
        .pwmDuty(pwmDuty), .pwmPinOut(pwmPinOut), .pwmPinOe(pwmPinOe),
        .correctionEnable(correctionEnable), .cfg(cfg), .deviceReset(deviceReset));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] exp);
        expQ.push_back(exp);
        i_fmcfg_host.readReg(dev, ptr);
    endtask
    task automatic wr(input logic [7:0] v, input logic ack);
        i_fmcfg_host.writeReg(FMCFG_BUS_ADDR, FMCFG_REG_CFG2, v, a);
        chk(8'(a), 8'(ack));
        repeat (2) @(negedge clk);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            measureDone = 1'b1;
            @(negedge clk);
            measureDone = 1'b0;
            @(negedge clk);
        end
    endtask
    always @(posedge rdDone) chk(rdByte, expQ.pop_front());
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk(cfg, FMCFG_CFG2_RESET);
        chk({6'h0, pwmPinOe, correctionEnable}, 8'h03);
        rd(FMCFG_BUS_ADDR, FMCFG_REG_CFG2, FMCFG_CFG2_RESET);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h05 | (8'h40 >> i), 1'b1);
            for (int f = 0; f < 4; f++) begin
                flags = fmcfg_flags_s'(4'h8 >> f);
                repeat (2) @(negedge clk);
                chk(8'(alertPinOe), 8'(i == f));
            end
            flags = '0;
        end
        $display("test alert done");
        for (int k = 0; k < 6; k++) begin
            d = 8'($random(seed)) & 8'h7F;
            if (!d[2]) d[1] = 1'b1;
            wr(d, 1'b1);
            rd(FMCFG_BUS_ADDR, FMCFG_REG_CFG2, d);
            chk({6'h0, speedCounterHold, correctionEnable}, {6'h0, !d[2], !d[1]});
        end
        i_fmcfg_host.writeReg(FMCFG_BUS_ADDR, 8'h02, 8'h55, a);
        rd(FMCFG_BUS_ADDR, 8'h02, FMCFG_READ_ZERO);
        rd(FMCFG_BUS_ADDR, FMCFG_REG_CFG2, d);
        rd(FMCFG_BUS_ADDR + 7'h01, FMCFG_REG_CFG2, 8'hFF);
        $display("test access done");
        wr(8'h3C, 1'b1);
        chk(8'(pwmPinOe), 8'h00);
        measureActive = 1'b1;
        repeat (2) @(negedge clk);
        chk(8'(pwmPinOut), 8'h01);
        wr(8'h3F, 1'b1);
        e = edges;
        repeat (32) @(negedge clk);
        chk(8'(edges - e), 8'h02);
        for (int w = 0; w < 2; w++) begin
            pwmWave = w[0];
            repeat (2) @(negedge clk);
            chk(8'(pwmPinOut), 8'(w));
        end
        measureActive = 1'b0;
        for (int k = 0; k < 4; k++) begin
            dutySetting = duties[k];
            repeat (2) @(negedge clk);
            chk(pwmDuty, duties[k] < FMCFG_MIN_DUTY ? FMCFG_DUTY_ZERO : duties[k]);
        end
        wr(8'h3A, 1'b1);
        e = edges;
        repeat (32) @(negedge clk);
        chk(8'(edges - e), 8'h00);
        wr(8'h3D, 1'b1);
        speedRegMode = 1'b1;
        pulse(10);
        chk(pwmDuty, FMCFG_RPM_FLOOR);
        wr(8'h3F, 1'b1);
        chk(pwmDuty, FMCFG_DUTY_ZERO);
        pulse(10);
        chk(pwmDuty, 8'h14);
        speedRegMode = 1'b0;
        $display("test pwm done");
        powerOnSensorFail = 1'b1;
        wr(8'h80, 1'b0);
        chk(8'(resets), 8'h01);
        chk(cfg, FMCFG_CFG2_RESET & 8'hDF);
        powerOnSensorFail = 1'b0;
        wr(8'hFF, 1'b0);
        chk(8'(resets), 8'h02);
        rd(FMCFG_BUS_ADDR, FMCFG_REG_CFG2, FMCFG_CFG2_RESET);
        $display("test soft reset done");
        stop_test();
    end
endmodule
